/* verilog/pcl_lookup.sv */
// Playfield colour lookup: APB palette, plane indexing, beam timing
//
// Behaviour
// - Index built from enabled plane bits, highest plane most significant.
// - Index selects one of 32 palette registers; its colour is output.
// - Single playfield uses zero to five planes, one to 32 colours.
// - Palette entry holds red 11:8, green 7:4, blue 3:0; top unused.
// - Entry zero is background, also shown in the border outside window.
// - Overlay video replaces every background-coloured pixel when enabled.
// - Dual playfield: two three-plane fields, each with its own 8 colours.
// - Line is 320 pixels in low resolution, 640 in high resolution.
// - Field has 262 lines, 200 visible NTSC; 312, 256 visible PAL.
// - Field repeats about every 1/60 s NTSC, 1/50 s PAL.
// - Interlace doubles visible lines to 400 NTSC and 512 PAL.
// - Resolution and interlace choices are independent, any combination.
// - Palette is write-only; reads return zero, not the stored colour.
`timescale 1ns/1ps
`default_nettype none
module pcl_lookup #(
	parameter int unsigned FIELD_CYC_NTSC = pcl_pkg::FIELD_CYC_NTSC,
	parameter int unsigned FIELD_CYC_PAL  = pcl_pkg::FIELD_CYC_PAL
) (
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire pcl_pkg::pcl_pix_t pix_in,
	input  wire logic             pix_in_valid,
	output logic                  pix_in_ready,
	output pcl_pkg::pcl_rgb_t     pix_out,
	output logic                  pix_out_valid,
	input  wire logic             pix_out_ready,
	output logic                  pix_out_border,
	output logic                  field_tick
);
	localparam int TW = pcl_pkg::TMR_W;

	pcl_pkg::pcl_ctrl_t ctrl;
	logic [11:0]        pal [pcl_pkg::PAL_N];
	pcl_pkg::pcl_pix_t  f_dat;
	logic               f_valid;
	logic               f_ready;
	logic               take;
	logic               wr_en;
	logic               hit_pal;
	logic               hit_ctrl;
	logic               hit_stat;
	logic [9:0]         x;
	logic [8:0]         line;
	logic               field_par;
	logic [9:0]         width;
	logic [8:0]         lines;
	logic [9:0]         vis_lim;
	logic [9:0]         vrow;
	logic               vis;
	logic               line_end;
	logic               field_end;
	logic [2:0]         np_eff;
	logic [5:0]         pmask;
	logic [5:0]         pl;
	logic [2:0]         pf1;
	logic [2:0]         pf2;
	logic [4:0]         lk_index;
	pcl_pkg::pcl_rgb_t  next_rgb;
	logic [TW-1:0]      tmr;

	// Pixel FIFO; its ready goes straight back to the source
	pcl_fifo #(
		.W (pcl_pkg::PIX_W),
		.D (pcl_pkg::FIFO_D)
	) u_fifo (
		.clk       (core_clk),
		.arst_n    (arst_n),
		.in_data   (pix_in),
		.in_valid  (pix_in_valid),
		.in_ready  (pix_in_ready),
		.out_data  (f_dat),
		.out_valid (f_valid),
		.out_ready (f_ready)
	);

	// Output stage drains the FIFO only when it has room
	assign f_ready = !pix_out_valid || pix_out_ready;
	assign take    = f_valid && f_ready;

	// APB decode
	assign hit_pal  = paddr <= pcl_pkg::PAL_END && paddr[1:0] == 2'h0;
	assign hit_ctrl = paddr == pcl_pkg::CTRL_ADDR;
	assign hit_stat = paddr == pcl_pkg::STAT_ADDR;
	assign wr_en    = psel && penable && pready && pwrite;

	// Zero-wait answer: ready rises for the access cycle only
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable
				&& !(hit_pal || hit_ctrl || hit_stat);
			prdata  <= '0; // Palette reads stay zero
			if (psel && !penable && !pwrite && hit_ctrl)
				prdata <= {23'h0, ctrl};
			else if (psel && !penable && !pwrite && hit_stat)
				prdata <= {12'h0, field_par, line, x};
		end

	// Control register; modes are free to combine
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			ctrl <= pcl_pkg::CTRL_RST;
		else if (wr_en && hit_ctrl)
			ctrl <= pwdata[pcl_pkg::CTRL_W-1:0];

	// Palette; upper twenty written bits are dropped
	for (genvar i = 0; i < pcl_pkg::PAL_N; i++)
	begin : g_pal
		always_ff @(posedge core_clk or negedge arst_n)
			if (!arst_n)
				pal[i] <= pcl_pkg::PAL_RST;
			else if (wr_en && hit_pal && paddr[6:2] == 5'(i))
				pal[i] <= pwdata[11:0];
	end

	// Beam geometry from resolution and standard
	assign width   = ctrl.hires ? pcl_pkg::W_HIRES : pcl_pkg::W_LORES;
	assign lines   = ctrl.pal ? pcl_pkg::LINES_PAL : pcl_pkg::LINES_NTSC;
	always_comb
	begin
		if (ctrl.lace)
			vis_lim = ctrl.pal ? pcl_pkg::VIS_PAL_IL : pcl_pkg::VIS_NTSC_IL;
		else
			vis_lim = ctrl.pal ? pcl_pkg::VIS_PAL : pcl_pkg::VIS_NTSC;
	end
	// Interlace counts rows of both fields together
	assign vrow      = ctrl.lace ? {line, field_par} : {1'b0, line};
	assign vis       = vrow < vis_lim;
	assign line_end  = x >= width - 10'h001;
	assign field_end = line_end && line >= lines - 9'h001;

	// Beam position advances once per pixel handed on
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			x         <= '0;
			line      <= '0;
			field_par <= 1'b0;
		end
		else if (take)
		begin
			x <= line_end ? 10'h000 : x + 10'h001;
			if (line_end)
				line <= field_end ? 9'h000 : line + 9'h001;
			if (field_end)
				field_par <= ctrl.lace ? !field_par : 1'b0;
		end

	// Field period timer; long counts shortened by parameter
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			tmr        <= '0;
			field_tick <= 1'b0;
		end
		else
		begin
			field_tick <= tmr == '0;
			if (tmr == '0)
				tmr <= ctrl.pal ? TW'(FIELD_CYC_PAL - 1)
					: TW'(FIELD_CYC_NTSC - 1);
			else
				tmr <= tmr - TW'(1);
		end

	// Plane limit: five single, six dual
	always_comb
	begin
		if (ctrl.dual)
			np_eff = ctrl.nplanes > pcl_pkg::MAX_DUAL
				? pcl_pkg::MAX_DUAL : ctrl.nplanes;
		else
			np_eff = ctrl.nplanes > pcl_pkg::MAX_SINGLE
				? pcl_pkg::MAX_SINGLE : ctrl.nplanes;
	end

	// Disabled planes read as zero
	for (genvar p = 0; p < pcl_pkg::PLANES; p++)
	begin : g_mask
		assign pmask[p] = 3'(p) < np_eff;
	end
	assign pl  = f_dat.planes & pmask;
	// Odd planes feed field one, even planes field two
	assign pf1 = {pl[4], pl[2], pl[0]};
	assign pf2 = {pl[5], pl[3], pl[1]};

	// Index forming and colour selection
	always_comb
	begin
		if (!vis)
			lk_index = 5'h00; // Border shows background
		else if (!ctrl.dual)
			lk_index = pl[4:0]; // Plane 5 is the top bit
		else if (ctrl.pf2_pri && pf2 != 3'h0)
			lk_index = {2'h1, pf2};
		else if (pf1 != 3'h0)
			lk_index = {2'h0, pf1};
		else if (pf2 != 3'h0)
			lk_index = {2'h1, pf2};
		else
			lk_index = 5'h00;
		next_rgb = pal[lk_index];
		if (ctrl.ovl_en && lk_index == 5'h00)
			next_rgb = f_dat.ovl;
	end

	// Registered output pixel
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			pix_out        <= '0;
			pix_out_valid  <= 1'b0;
			pix_out_border <= 1'b0;
		end
		else if (f_ready)
		begin
			pix_out_valid <= f_valid;
			if (take)
			begin
				pix_out        <= next_rgb;
				pix_out_border <= !vis;
			end
		end

	// Checks, all in the core clock domain
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	AST_DEPTH_PICK: assert property (
		take && vis && !ctrl.dual |-> lk_index == (f_dat.planes[4:0]
			& pmask[4:0]))
		else $error("index not built from plane bits");

	AST_PAL_OUT: assert property (
		take && !ctrl.ovl_en |=> pix_out == $past(pal[lk_index]))
		else $error("output colour not palette entry");

	AST_SINGLE_MAX: assert property (
		take && !ctrl.dual && ctrl.nplanes > 3'h5 |-> !pl[5])
		else $error("sixth plane used in single mode");

	AST_BORDER_BG: assert property (
		take && !vis && !ctrl.ovl_en
		|=> pix_out_border && pix_out == $past(pal[0]))
		else $error("border not background colour");

	AST_OVERLAY: assert property (
		take && ctrl.ovl_en && lk_index == 5'h00
		|=> pix_out == $past(f_dat.ovl))
		else $error("overlay not substituted");

	AST_DUAL_SET: assert property (
		take && ctrl.dual && vis |-> lk_index < 5'h10
			&& (lk_index[3] == 1'b0 || lk_index[2:0] == pf2))
		else $error("dual playfield colour set wrong");

	AST_X_WRAP: assert property (
		take && x == width - 10'h001 && $stable(ctrl) |=> x == 10'h000)
		else $error("line width wrong");

	AST_FIELD_WRAP: assert property (
		take && field_end && $stable(ctrl) |=> line == 9'h000
			&& field_par == ($past(ctrl.lace) && !$past(field_par)))
		else $error("field length or parity wrong");

	AST_TICK_GAP: assert property (
		field_tick |=> !field_tick ##1 !field_tick)
		else $error("field period too short");

	AST_PAL_WO: assert property (
		psel && penable && pready && !pwrite && hit_pal |-> prdata == '0)
		else $error("palette read not zero");

	AST_MASK: assert property (
		take && ctrl.nplanes == 3'h1 && !ctrl.dual |-> lk_index[4:1] == 4'h0)
		else $error("disabled plane bit used");

	AST_RGB_FIELDS: assert property (
		take && !ctrl.ovl_en
		|=> pix_out.r == $past(pal[lk_index][11:8])
			&& pix_out.g == $past(pal[lk_index][7:4])
			&& pix_out.b == $past(pal[lk_index][3:0]))
		else $error("colour fields out of place");

	AST_PAL_STORE: assert property (
		wr_en && hit_pal
		|=> pal[$past(paddr[6:2])] == $past(pwdata[11:0]))
		else $error("palette entry not stored");

	AST_FEW_PLANES: assert property (
		take && vis && !ctrl.dual && ctrl.nplanes == 3'h3
		|-> lk_index < 5'h08)
		else $error("three planes exceed eight colours");

	AST_DUAL_FIELD: assert property (
		take && ctrl.dual && vis && lk_index != 5'h00
		|-> lk_index[2:0] == (lk_index[3] ? pf2 : pf1))
		else $error("dual playfield index from wrong planes");

	AST_LORES_WRAP: assert property (
		take && !ctrl.hires && x == pcl_pkg::W_LORES - 10'h001
		|=> x == 10'h000)
		else $error("low resolution line not full width");

	AST_HIRES_RUN: assert property (
		take && ctrl.hires && x == pcl_pkg::W_LORES - 10'h001
		|=> x == pcl_pkg::W_LORES)
		else $error("high resolution line ended early");

	AST_BORDER_NTSC: assert property (
		take && !ctrl.lace && !ctrl.pal |=> pix_out_border
			== ({1'b0, $past(line)} >= pcl_pkg::VIS_NTSC))
		else $error("visible line count wrong");

	AST_VIS_PAL: assert property (
		ctrl.pal && !ctrl.lace
		|-> vis == ({1'b0, line} < pcl_pkg::VIS_PAL))
		else $error("visible line count wrong in PAL");

	AST_BORDER_LACE: assert property (
		take && ctrl.lace && !ctrl.pal |=> pix_out_border
			== ({$past(line), $past(field_par)} >= pcl_pkg::VIS_NTSC_IL))
		else $error("interlaced visible line count wrong");

	AST_LACE_HIRES: assert property (
		ctrl.hires && ctrl.lace |-> width == pcl_pkg::W_HIRES
			&& vis_lim >= pcl_pkg::VIS_NTSC_IL)
		else $error("resolution and interlace not combined");

	AST_TICK_LOAD: assert property (
		field_tick |-> tmr == ($past(ctrl.pal) ? TW'(FIELD_CYC_PAL - 1)
			: TW'(FIELD_CYC_NTSC - 1)))
		else $error("field period not loaded");

	AST_APB_ONE: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("ready not single cycle");

endmodule : pcl_lookup
`default_nettype wire

/* verilog/pcl_pkg.sv */
// Shared constants and types for the playfield colour lookup block
package pcl_pkg;

	// APB register byte addresses
	localparam logic [11:0] PAL_BASE    = 12'h000;
	localparam logic [11:0] PAL_END     = 12'h07c;
	localparam logic [11:0] CTRL_ADDR   = 12'h080;
	localparam logic [11:0] STAT_ADDR   = 12'h084;

	// Palette shape and colour field positions
	localparam int          PAL_N       = 32;
	localparam int          IDX_W       = 5;
	localparam int          RED_LSB     = 8;
	localparam int          GRN_LSB     = 4;
	localparam int          BLU_LSB     = 0;
	localparam logic [11:0] PAL_RST     = 12'h000;

	// Plane counts
	localparam int          PLANES      = 6;
	localparam logic [2:0]  MAX_SINGLE  = 3'h5;
	localparam logic [2:0]  MAX_DUAL    = 3'h6;

	// Line widths and field heights
	localparam logic [9:0]  W_LORES     = 10'h140;
	localparam logic [9:0]  W_HIRES     = 10'h280;
	localparam logic [8:0]  LINES_NTSC  = 9'h106;
	localparam logic [8:0]  LINES_PAL   = 9'h138;
	localparam logic [9:0]  VIS_NTSC    = 10'h0c8;
	localparam logic [9:0]  VIS_PAL     = 10'h100;
	localparam logic [9:0]  VIS_NTSC_IL = 10'h190;
	localparam logic [9:0]  VIS_PAL_IL  = 10'h200;

	// Field rate timing
	localparam int          CLK_HZ      = 200000000;
	localparam int          RATE_NTSC   = 60;
	localparam int          RATE_PAL    = 50;
	localparam int          FIELD_CYC_NTSC = CLK_HZ / RATE_NTSC;
	localparam int          FIELD_CYC_PAL  = CLK_HZ / RATE_PAL;
	localparam int          TMR_W       = 22;

	// Control register, bits 8..0 of the written word
	typedef struct packed {
		logic       ovl_en;
		logic       pal;
		logic       lace;
		logic       hires;
		logic       pf2_pri;
		logic       dual;
		logic [2:0] nplanes;
	} pcl_ctrl_t;
	localparam int          CTRL_W      = 9;
	localparam logic [8:0]  CTRL_RST    = 9'h000;

	// Colour value
	typedef struct packed {
		logic [3:0] r;
		logic [3:0] g;
		logic [3:0] b;
	} pcl_rgb_t;

	// Incoming pixel: plane bits plus overlay video
	typedef struct packed {
		logic [5:0] planes;
		pcl_rgb_t   ovl;
	} pcl_pix_t;
	localparam int          PIX_W       = 18;
	localparam int          FIFO_D      = 4;

endpackage : pcl_pkg

/* verilog/pcl_fifo.sv */
// Shift-register FIFO, head entry is read straight from a register
`timescale 1ns/1ps
`default_nettype none
module pcl_fifo #(
	parameter int W = 18,
	parameter int D = 4
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int CW = $clog2(D + 1);

	logic [W-1:0]  q [D];
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic [CW-1:0] wr_pos;
	logic          push;
	logic          pop;

	// Handshakes; a pop frees a slot, so write one lower
	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign wr_pos   = pop ? cnt - CW'(1) : cnt;
	assign next_cnt = cnt + CW'(push) - CW'(pop);
	assign out_data = q[0];

	// Fill level and registered flags
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			cnt       <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end
		else
		begin
			cnt       <= next_cnt;
			in_ready  <= next_cnt < CW'(D);
			out_valid <= next_cnt != '0;
		end

	// Entries shift toward the head on each pop
	for (genvar i = 0; i < D; i++)
	begin : g_ent
		always_ff @(posedge clk or negedge arst_n)
			if (!arst_n)
				q[i] <= '0;
			else if (push && wr_pos == CW'(i))
				q[i] <= in_data;
			else if (pop)
				q[i] <= (i < D - 1) ? q[(i < D - 1) ? i + 1 : i] : q[i];
	end
endmodule : pcl_fifo
`default_nettype wire

/* bench/pcl_monitor.sv */
// Video sink model that takes coloured pixels and logs them
`timescale 1ns/1ps
`default_nettype none
module pcl_monitor (
	input  wire logic              core_clk,
	input  wire pcl_pkg::pcl_rgb_t pix,
	input  wire logic              pix_valid,
	input  wire logic              border,
	input  wire logic              stall,
	input  wire logic              slow,
	output logic                   ready
);
	logic [12:0] q [$];
	logic        tog = 1'b0;

	// Slow mode takes every other cycle, to stretch the output side
	always_comb ready = !stall && (!slow || tog);

	// Log colour and border flag of each pixel handed on
	always @(posedge core_clk)
	begin
		tog <= !tog;
		if (pix_valid && ready)
			q.push_back({border, pix});
	end
endmodule : pcl_monitor
`default_nettype wire

/* bench/pcl_lookup_bench.sv */
// Self-checking bench for the playfield colour lookup block
`timescale 1ns/1ps
`default_nettype none
module pcl_lookup_bench;
	typedef struct packed {
		logic [8:0] c;
		logic [5:0] p;
		logic [5:0] e;
	} pcl_row_t;
	localparam logic [11:0] OVL = 12'h9c3;
	logic              core_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [11:0]       paddr = 12'h000;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	pcl_pkg::pcl_pix_t pix_in = '0;
	logic              pix_in_valid = 1'b0;
	logic              pix_in_ready;
	pcl_pkg::pcl_rgb_t pix_out;
	logic              pix_out_valid;
	logic              pix_out_ready;
	logic              pix_out_border;
	logic              field_tick;
	logic              stall = 1'b0;
	logic              slow = 1'b0;
	int                fails = 0;
	int                comparisons = 0;
	logic [31:0]       rd;
	logic              er;
	pcl_row_t          rows [15];
	int                n;
	int                g;

	always #2.5 core_clk = !core_clk;

	// Short field periods keep the run small
	pcl_lookup #(.FIELD_CYC_NTSC(20), .FIELD_CYC_PAL(24)) dut (
		.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pix_in(pix_in), .pix_in_valid(pix_in_valid),
		.pix_in_ready(pix_in_ready), .pix_out(pix_out),
		.pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
		.pix_out_border(pix_out_border), .field_tick(field_tick));

	pcl_monitor mon (
		.core_clk(core_clk), .pix(pix_out), .pix_valid(pix_out_valid),
		.border(pix_out_border), .stall(stall), .slow(slow),
		.ready(pix_out_ready));

	// Distinct colour for each palette entry
	function automatic logic [11:0] col(input int i);
		return 12'(i) * 12'h083 + 12'h005;
	endfunction : col

	task automatic stop_test;
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	task automatic hang;
		fails++;
		stop_test();
	endtask : hang

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready, bounded
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20)
			hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Offer one pixel and hold it until taken; valid stays up
	task automatic send(input logic [5:0] p);
		int k;
		pix_in_valid <= 1'b1;
		pix_in <= {p, OVL};
		for (k = 0; k < 5000; k++)
		begin
			@(posedge core_clk);
			if (pix_in_ready === 1'b1)
				break;
		end
		if (k == 5000)
			hang();
	endtask : send

	task automatic stream(input int cnt, input logic [5:0] p);
		for (int i = 0; i < cnt; i++)
			send(p);
		pix_in_valid <= 1'b0;
	endtask : stream

	task automatic get(input logic [11:0] c, input logic b);
		int k;
		for (k = 0; k < 100 && mon.q.size() == 0; k++)
			@(posedge core_clk);
		if (mon.q.size() == 0)
			hang();
		chk({19'h0, mon.q[0]}, {19'h0, b, c});
		void'(mon.q.pop_front());
	endtask : get

	// Bounded wait until the sink has logged cnt pixels
	task automatic drain(input int cnt);
		int k;
		for (k = 0; k < 2000 && mon.q.size() < cnt; k++)
			@(posedge core_clk);
		if (mon.q.size() < cnt)
			hang();
	endtask : drain

	// Reset, then load the palette with junk in the unused top bits
	task automatic do_reset;
		arst_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk({pix_in_ready, pix_out_valid}, 0);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk(pix_in_ready, 1);
		mon.q.delete();
		for (int i = 0; i < 32; i++)
			apb(1'b1, 12'(4 * i), 32'hffff_f000 | col(i));
	endtask : do_reset

	task automatic tick_gap;
		int k;
		for (k = 0; k < 100; k++)
		begin
			@(posedge core_clk);
			if (field_tick === 1'b1)
				break;
		end
		if (k == 100)
			hang();
		for (g = 1; g < 100; g++)
		begin
			@(posedge core_clk);
			if (field_tick === 1'b1)
				break;
		end
	endtask : tick_gap

	// Main sequence: register reads and a slowed hires line, then table rows, then the awkward cases
	initial
	begin
		rows = '{'{9'h005, 6'h36, 6'h16}, '{9'h003, 6'h1d, 6'h05},
			'{9'h001, 6'h01, 6'h01}, '{9'h002, 6'h3e, 6'h02},
			'{9'h004, 6'h0f, 6'h0f}, '{9'h000, 6'h3f, 6'h00},
			'{9'h007, 6'h3f, 6'h1f}, '{9'h00e, 6'h05, 6'h03},
			'{9'h00e, 6'h2f, 6'h03}, '{9'h01e, 6'h2f, 6'h0f},
			'{9'h00e, 6'h2a, 6'h0f}, '{9'h00e, 6'h02, 6'h09},
			'{9'h102, 6'h00, 6'h3f}, '{9'h102, 6'h01, 6'h01},
			'{9'h10e, 6'h00, 6'h3f}};
		do_reset();
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 0);
		apb(1'b0, 12'h0a0, 32'h0);
		chk({rd[30:0], er}, 1);
		// Hires with interlace, output side slowed down
		slow <= 1'b1;
		apb(1'b1, pcl_pkg::CTRL_ADDR, 32'h061);
		stream(640, 6'h01);
		drain(640);
		slow <= 1'b0;
		apb(1'b0, pcl_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h0000_0400);
		mon.q.delete();
		foreach (rows[i])
		begin
			apb(1'b1, pcl_pkg::CTRL_ADDR, {23'h0, rows[i].c});
			send(rows[i].p);
			pix_in_valid <= 1'b0;
			get(rows[i].e == 6'h3f ? OVL : col(rows[i].e), 1'b0);
		end
		// Fill the buffer against a stalled sink, then drain in order
		apb(1'b1, pcl_pkg::CTRL_ADDR, 32'h005);
		stall <= 1'b1;
		n = 0;
		pix_in_valid <= 1'b1;
		pix_in <= {6'h00, OVL};
		repeat (12)
		begin
			@(posedge core_clk);
			if (pix_in_ready === 1'b1)
			begin
				n++;
				pix_in <= {6'(n), OVL};
			end
		end
		chk(pix_in_ready, 0);
		chk(n >= 4, 1);
		pix_in_valid <= 1'b0;
		stall <= 1'b0;
		for (int i = 0; i < n; i++)
			get(col(i), 1'b0);
		for (int j = 0; j < 2; j++)
		begin
			apb(1'b1, pcl_pkg::CTRL_ADDR, {24'h0, j[0], 7'h0});
			repeat (2) tick_gap();
			chk(g, j ? 24 : 20);
		end
		// Fresh beam: first pixel past the visible lines is border
		do_reset();
		apb(1'b1, pcl_pkg::CTRL_ADDR, 32'h001);
		stream(64001, 6'h01);
		drain(64001);
		chk({19'h0, mon.q[63999]}, {20'h0, col(1)});
		chk({19'h0, mon.q[64000]}, {20'h1, col(0)});
		apb(1'b0, pcl_pkg::STAT_ADDR, 32'h0);
		chk(rd, (200 << 10) | 1);
		// Rest of the field; the beam wraps back to a visible line
		stream(19840, 6'h01);
		drain(83841);
		chk({19'h0, mon.q[83839]}, {20'h1, col(0)});
		chk({19'h0, mon.q[83840]}, {20'h0, col(1)});
		apb(1'b0, pcl_pkg::STAT_ADDR, 32'h0);
		chk(rd, 32'h0000_0001);
		stop_test();
	end
endmodule : pcl_lookup_bench
`default_nettype wire
